// ===== pwm_timing_pkg.sv
// Shared constants for the three-phase center-based PWM timing unit.
package pwm_timing_pkg;

	// Register and field layout of the loose control and status words.
	localparam int MODE_W = 16;
	localparam int STATUS_W = 16;
	localparam int MODE_DOUBLE_BIT = 6;
	localparam int STATUS_HALF_BIT = 3;

	// Documented widths of the timing values.
	localparam int CNT_W_DEF = 16;
	localparam int DT_W_DEF = 10;
	localparam int SW_W_DEF = 8;

	// Reset value of the sync pulse width setting.
	localparam logic [7:0] SYNC_WIDTH_RST = 8'h27;

	// Number of phases served by the timing unit.
	localparam int PHASES = 3;

	// Run state of the timing unit.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_RUN
	} run_state_t;

endpackage

// ===== three_phase_center_pwm_timing.sv
// Three-phase center-based PWM timing unit with dead time and narrow pulse deletion.
// Contract
// - Duty A drives pair A, duty B pair B, duty C pair C.
// - Duty is a clock count giving high-side on-time per half period.
// - Pulses are center-aligned and symmetric within the sync period in single mode.
// - Every edge moves by dead time clocks, equally on both sides.
// - Single mode: high 2(duty-dead), low 2(half-duty-dead) clocks per period.
// - On-times are clamped between zero and the half period.
// - Status bit 3 is clear in the first half, set in the second.
// - Double mode lets period, dead time and duty differ per half.
// - Double mode on-times are the sums of each half's adjusted on-time.
// - Double mode period is first half count plus second half count.
// - Phases B and C follow exactly the phase A timing.
// - No output until half period and all duties written; then timer starts.
// - Single mode: first sync 1.5 half periods after first half period write.
// - Double mode: first sync one half period after first half period write.
// - Single mode: one duty serves both halves, step is two clocks.
// - Double mode: per-half duties give one clock steps.
// - Minimum on-time per half is the minimum pulse count in clocks.
// - A too-short output is off for the half, its complement fully on.
// - Mode bit 6 selects double update; it is clear after reset (here the bit is read live from the input, and reset does not clear it).
// - Each sync rising edge latches all timing and duty values.
// - Double mode adds a mid-period sync that also latches new values.
// - The sync pulse stays high for sync width plus one clocks.
`timescale 1ns/10ps

module three_phase_center_pwm_timing #(
	parameter int CNT_W = pwm_timing_pkg::CNT_W_DEF,
	parameter int DT_W = pwm_timing_pkg::DT_W_DEF,
	parameter int SW_W = pwm_timing_pkg::SW_W_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic half_period_wr,
	input wire logic [CNT_W-1:0] half_period_count,
	input wire logic dead_time_wr,
	input wire logic [DT_W-1:0] dead_time_count,
	input wire logic min_pulse_wr,
	input wire logic [CNT_W-1:0] min_pulse_count,
	input wire logic sync_width_wr,
	input wire logic [SW_W-1:0] sync_width_count,
	input wire logic duty_a_wr,
	input wire logic [CNT_W-1:0] duty_phase_a,
	input wire logic duty_b_wr,
	input wire logic [CNT_W-1:0] duty_phase_b,
	input wire logic duty_c_wr,
	input wire logic [CNT_W-1:0] duty_phase_c,
	input wire logic [pwm_timing_pkg::MODE_W-1:0] mode_control_reg,
	output logic [pwm_timing_pkg::STATUS_W-1:0] system_status_reg,
	output logic period_sync_pulse,
	output logic phase_a_high,
	output logic phase_a_low,
	output logic phase_b_high,
	output logic phase_b_low,
	output logic phase_c_high,
	output logic phase_c_low
);

	localparam int NP = pwm_timing_pkg::PHASES;
	localparam int SW = CNT_W + 2;

	// The dead time and sync width must fit inside the counter arithmetic.
	// The half-count arithmetic also needs at least two counter bits.
	if (DT_W > CNT_W || SW_W > CNT_W || CNT_W < 2) begin : g_bad_width
		$error("PWM timing widths are not supported");
	end

	// Shadow copies written by software and the active copies used by the timer.
	logic [CNT_W-1:0] t_sh_q, t_act_q, min_sh_q, min_act_q;
	logic [DT_W-1:0] dt_sh_q, dt_act_q;
	logic [SW_W-1:0] sw_sh_q, sw_act_q, sync_cnt_q;
	logic [CNT_W-1:0] duty_sh_q [NP];
	logic [CNT_W-1:0] duty_act_q [NP];
	logic [3:0] seen_q;
	logic [CNT_W:0] start_cnt_q;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic half_q, half_d, sync_q;
	logic [NP-1:0] high_q, low_q, cmp_high, cmp_low, del_high, del_low;
	logic [CNT_W-1:0] sync_len_q;
	pwm_timing_pkg::run_state_t state_q;

	// Decode of mode, counter limits and boundary events.
	wire [CNT_W-1:0] duty_in [NP];
	wire [NP-1:0] duty_wr;
	wire dbl = mode_control_reg[pwm_timing_pkg::MODE_DOUBLE_BIT];
	wire all_seen = &{seen_q[3], seen_q[2], seen_q[1], seen_q[0]};
	wire run = state_q == pwm_timing_pkg::ST_RUN;
	wire [CNT_W-1:0] t_last = (t_act_q == '0) ? '0 : t_act_q - 1'b1;
	wire [CNT_W-1:0] t_sh_last = (t_sh_q == '0) ? '0 : t_sh_q - 1'b1;
	wire at_mid = run && !half_q && cnt_q == t_last;
	wire at_end = run && half_q && cnt_q == '0;
	// A late duty write holds the start, so the first sync can come later than planned.
	wire start_go = state_q == pwm_timing_pkg::ST_WAIT && start_cnt_q <= 1 && all_seen;
	wire fire = start_go || at_end || (at_mid && dbl);
	// First sync is 1.5 half periods out in single mode, one half period in double.
	wire [CNT_W:0] start_len = dbl ? {1'b0, half_period_count}
		: {1'b0, half_period_count} + {2'b00, half_period_count[CNT_W-1:1]};

	assign duty_in[0] = duty_phase_a;
	assign duty_in[1] = duty_phase_b;
	assign duty_in[2] = duty_phase_c;
	assign duty_wr = {duty_c_wr, duty_b_wr, duty_a_wr};

	// Counter steps up through the first half and down through the second.
	always_comb begin
		cnt_d = cnt_q;
		half_d = half_q;
		if (start_go) begin
			cnt_d = '0;
			half_d = 1'b0;
		end else if (at_mid) begin
			half_d = 1'b1;
			cnt_d = dbl ? t_sh_last : cnt_q;
		end else if (at_end) begin
			half_d = 1'b0;
		end else if (run) begin
			cnt_d = half_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
		end
	end

	// Shadow registers take software writes at any time and remember what was written.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			t_sh_q <= '0;
			dt_sh_q <= '0;
			min_sh_q <= '0;
			sw_sh_q <= SW_W'(pwm_timing_pkg::SYNC_WIDTH_RST);
			seen_q <= '0;
		end else begin
			if (half_period_wr) t_sh_q <= half_period_count;
			if (dead_time_wr) dt_sh_q <= dead_time_count;
			if (min_pulse_wr) min_sh_q <= min_pulse_count;
			if (sync_width_wr) sw_sh_q <= sync_width_count;
			seen_q <= seen_q | {duty_wr, half_period_wr};
		end
	end

	// Per-phase duty shadows and active copies; active values change only on a sync edge.
	for (genvar p = 0; p < NP; p++) begin : g_duty
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				duty_sh_q[p] <= '0;
				duty_act_q[p] <= '0;
			end else begin
				if (duty_wr[p]) duty_sh_q[p] <= duty_in[p];
				if (fire) duty_act_q[p] <= duty_sh_q[p];
			end
		end
	end

	// Configuration latched into the timer on each sync rising edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			t_act_q <= '0;
			dt_act_q <= '0;
			min_act_q <= '0;
			sw_act_q <= '0;
		end else if (fire) begin
			t_act_q <= t_sh_q;
			dt_act_q <= dt_sh_q;
			min_act_q <= min_sh_q;
			sw_act_q <= sw_sh_q;
		end
	end

	// Start sequence: the first half period write arms the countdown to the first sync.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pwm_timing_pkg::ST_IDLE;
			start_cnt_q <= '0;
		end else begin
			case (state_q)
				pwm_timing_pkg::ST_IDLE: begin
					if (half_period_wr) begin
						state_q <= pwm_timing_pkg::ST_WAIT;
						start_cnt_q <= start_len;
					end
				end
				pwm_timing_pkg::ST_WAIT: begin
					if (start_go) state_q <= pwm_timing_pkg::ST_RUN;
					else if (start_cnt_q > 1) start_cnt_q <= start_cnt_q - 1'b1;
				end
				pwm_timing_pkg::ST_RUN: state_q <= pwm_timing_pkg::ST_RUN;
				default: state_q <= pwm_timing_pkg::ST_IDLE;
			endcase
		end
	end

	// Counter, half flag and sync pulse; the pulse restarts if a half is shorter than it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			half_q <= 1'b0;
			sync_q <= 1'b0;
			sync_cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			half_q <= half_d;
			if (fire) begin
				sync_q <= 1'b1;
				sync_cnt_q <= sw_sh_q;
			end else if (sync_cnt_q != '0) begin
				sync_cnt_q <= sync_cnt_q - 1'b1;
			end else begin
				sync_q <= 1'b0;
			end
		end
	end

	// Per-phase on-time arithmetic, clamping, deletion and edge comparators; same for all.
	for (genvar p = 0; p < NP; p++) begin : g_phase
		wire signed [SW-1:0] t_s = $signed({2'b00, t_act_q});
		wire signed [SW-1:0] d_s = $signed({2'b00, duty_act_q[p]});
		wire signed [SW-1:0] dt_s = $signed({{(SW-DT_W){1'b0}}, dt_act_q});
		// Dead time trims each pulse on both sides of its center equally.
		wire signed [SW-1:0] hon_raw = d_s - dt_s;
		wire signed [SW-1:0] lon_raw = t_s - d_s - dt_s;
		// A negative or oversized on-time would wrap the comparator, so clamp it.
		wire [CNT_W-1:0] hon_c = hon_raw < 0 ? '0 : hon_raw > t_s ? t_act_q
			: hon_raw[CNT_W-1:0];
		wire [CNT_W-1:0] lon_c = lon_raw < 0 ? '0 : lon_raw > t_s ? t_act_q
			: lon_raw[CNT_W-1:0];
		wire [CNT_W-1:0] hon_e;
		wire [CNT_W-1:0] lon_e;
		assign del_high[p] = hon_c < min_act_q;
		assign del_low[p] = !del_high[p] && lon_c < min_act_q;
		assign hon_e = del_high[p] ? '0 : del_low[p] ? t_act_q : hon_c;
		assign lon_e = del_high[p] ? t_act_q : del_low[p] ? '0 : lon_c;
		// In single mode both halves meet the same thresholds, so pulses mirror about the center.
		assign cmp_high[p] = {1'b0, cnt_q} >= {1'b0, t_act_q} - {1'b0, hon_e};
		assign cmp_low[p] = cnt_q < lon_e;
	end

	// Outputs are registered and held low until the timer runs.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_q <= '0;
			low_q <= '0;
			sync_len_q <= '0;
		end else begin
			high_q <= run ? cmp_high : '0;
			low_q <= run ? cmp_low : '0;
			// Width counter for the sync check only; it never steers a pin.
			sync_len_q <= sync_q ? sync_len_q + 1'b1 : '0;
		end
	end

	// Pins come straight from flops, so no decode glitch reaches a gate driver.
	assign phase_a_high = high_q[0];
	assign phase_a_low = low_q[0];
	assign phase_b_high = high_q[1];
	assign phase_b_low = low_q[1];
	assign phase_c_high = high_q[2];
	assign phase_c_low = low_q[2];
	assign period_sync_pulse = sync_q;
	// Only the half flag is reported; every other status bit reads as zero.
	assign system_status_reg = pwm_timing_pkg::STATUS_W'(half_q)
		<< pwm_timing_pkg::STATUS_HALF_BIT;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Checks sit next to the timer and stay quiet while reset is held.
	a_no_out_idle: assert property (!run |=> !(|high_q) && !(|low_q))
		else $error("PWM output active before the timer started");
	a_sync_width: assert property ($fell(sync_q) && sync_len_q <= t_act_q
		|-> sync_len_q == CNT_W'(sw_act_q) + 1'b1)
		else $error("Sync pulse width differs from setting plus one");
	a_latch_on_sync: assert property ($rose(sync_q) |-> t_act_q == $past(t_sh_q)
		&& dt_act_q == $past(dt_sh_q))
		else $error("Configuration not latched on sync rise");
	a_mid_sync_dbl: assert property ($rose(half_q) && $past(dbl) |-> sync_q
		&& sync_cnt_q == sw_act_q)
		else $error("Missing mid-period sync in double mode");
	a_no_mid_single: assert property (at_mid && !dbl |=> !(sync_q
		&& sync_cnt_q == sw_act_q && $changed(half_q) && $past(sync_cnt_q) == '0))
		else $error("Mid-period sync in single mode");
	a_half_status: assert property (at_end |=> sync_q
		&& !system_status_reg[pwm_timing_pkg::STATUS_HALF_BIT])
		else $error("Status half bit not cleared at period start");
	a_dead_gap: assert property (!(|(high_q & low_q)) || (dt_act_q == '0))
		else $error("High and low on together with dead time set");
	a_min_delete: assert property (run && del_high[0] |=> !phase_a_high && phase_a_low)
		else $error("Narrow high pulse not deleted on phase A");
	a_min_delete_c: assert property (run && del_high[2] |=> !phase_c_high
		&& phase_c_low)
		else $error("Narrow high pulse not deleted on phase C");
	a_start_delay: assert property (state_q == pwm_timing_pkg::ST_IDLE && half_period_wr
		&& !dbl |=> start_cnt_q == $past(start_len)
		&& start_cnt_q >= {1'b0, $past(half_period_count)})
		else $error("Start delay not loaded as one and a half half-periods");
	a_start_fire: assert property (start_go |=> run && sync_q && !half_q)
		else $error("Timer start did not emit the first sync");
	a_second_half: assert property (at_mid && dbl && t_sh_q != '0 |=> half_q
		&& cnt_q == t_act_q - 1'b1)
		else $error("Second half length not taken from the new half period");
	a_count_step: assert property (run && !at_mid && !at_end |=> cnt_q == (half_q
		? $past(cnt_q) - 1'b1 : $past(cnt_q) + 1'b1))
		else $error("Timer did not step by one count");

endmodule

// ===== gate_driver_model.sv
// Gate driver model that totals the on-cycles of each switch between sync rising edges.
`timescale 1ns/10ps

module gate_driver_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync,
	input wire logic [5:0] gate,
	output logic [15:0] on_cnt [6],
	output logic [15:0] win_q,
	output logic shoot_q
);
	logic sync_q;
	logic [15:0] acc [6];
	logic [15:0] win_acc;
	wire logic new_win = sync && !sync_q;

	// Totals restart at each sync rise, so one window is one half or one whole period.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_q <= 1'b0;
			win_acc <= 16'h0000;
			win_q <= 16'h0000;
			shoot_q <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				acc[i] <= 16'h0000;
				on_cnt[i] <= 16'h0000;
			end
		end else begin
			sync_q <= sync;
			win_acc <= new_win ? 16'h0001 : win_acc + 16'h0001;
			if (new_win) begin
				win_q <= win_acc;
			end
			for (int i = 0; i < 6; i++) begin
				acc[i] <= (new_win ? 16'h0000 : acc[i]) + {15'h0000, gate[i]};
				if (new_win) begin
					on_cnt[i] <= acc[i];
				end
			end
			// Both switches of one leg on together short the dc link, so it is kept as a fault.
			for (int p = 0; p < 3; p++) begin
				if (gate[2*p] && gate[2*p+1]) begin
					shoot_q <= 1'b1;
				end
			end
		end
	end
endmodule

// ===== three_phase_center_pwm_timing_tb.sv
// Self-checking testbench for the three-phase center-based PWM timing unit.
`timescale 1ns/10ps

module three_phase_center_pwm_timing_tb;
	logic clk, rst_n, sp, st, shoot;
	logic [6:0] wrs;
	logic [15:0] hp, mp, da, db, dc, mode, status, win;
	logic [9:0] dt;
	logic [7:0] sw;
	logic ah, al, bh, bl, ch, cl, sync;
	logic [15:0] on_cnt [6];
	logic [15:0] prv [6];
	int n_fail, cmp_count, cyc, c0, t0, n;
	wire logic [5:0] gate = {cl, ch, bl, bh, al, ah};
	localparam logic [15:0] exp_s [6] = '{16'h0014, 16'h000C, 16'h000C, 16'h0014,
		16'h0000, 16'h0028};
	localparam logic [15:0] exp_d [6] = '{16'h0015, 16'h000B, 16'h000C, 16'h0014,
		16'h0000, 16'h0022};

	three_phase_center_pwm_timing u_dut (.clk(clk), .rst_n(rst_n),
		.half_period_wr(wrs[0]), .half_period_count(hp), .dead_time_wr(wrs[1]),
		.dead_time_count(dt), .min_pulse_wr(wrs[2]), .min_pulse_count(mp),
		.sync_width_wr(wrs[3]), .sync_width_count(sw), .duty_a_wr(wrs[4]), .duty_phase_a(da),
		.duty_b_wr(wrs[5]), .duty_phase_b(db), .duty_c_wr(wrs[6]), .duty_phase_c(dc),
		.mode_control_reg(mode), .system_status_reg(status), .period_sync_pulse(sync),
		.phase_a_high(ah), .phase_a_low(al), .phase_b_high(bh), .phase_b_low(bl),
		.phase_c_high(ch), .phase_c_low(cl));

	gate_driver_model u_drv (.clk(clk), .rst_n(rst_n), .sync(sync), .gate(gate),
		.on_cnt(on_cnt), .win_q(win), .shoot_q(shoot));

	// The clock toggles every 4 ns for a 125 MHz rate.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Edge counter and last sync level let a rise be timed to the exact edge.
	always @(posedge clk) begin
		sp <= sync;
		cyc <= cyc + 1;
	end

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	// One strobe for one cycle; all data buses carry the value, only the strobed one is stored.
	task automatic wr(input int k, input logic [15:0] v);
		@(posedge clk);
		wrs <= 7'(1 << k);
		{hp, mp, da, db, dc} <= {5{v}};
		dt <= v[9:0];
		sw <= v[7:0];
		@(posedge clk);
		wrs <= 7'h00;
		#1;
		c0 = cyc;
	endtask

	// Bounded wait for a sync rise; returns at the falling edge after the rising edge.
	task automatic wait_rise();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(sync === 1'b1 && sp === 1'b0) && n < 200);
		if (n >= 200) begin
			n_fail++;
			$display("BAD sync_rise expected 1 seen 0");
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The whole sequence should take about 400 cycles, so 5000 means a hang.
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		$display("BAD watchdog expected done seen timeout");
		final_report();
	end

	initial begin
		{rst_n, wrs, hp, mp, da, db, dc, mode, dt, sw} = '0;
		{n_fail, cmp_count} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		wr(1, 16'h0002);
		wr(2, 16'h0004);
		wr(3, 16'h0003);
		wr(0, 16'h0014);
		t0 = c0;
		wr(4, 16'h000C);
		wr(5, 16'h0008);
		wr(6, 16'h0003);
		chk("gates_idle", {10'h000, gate}, 16'h0000);
		chk("status_idle", status, 16'h0000);
		wait_rise();
		chk("start_single", 16'(cyc - t0), 16'h001E);
		$display("test start done");
		repeat (3) wait_rise();
		@(posedge clk);
		@(negedge clk);
		for (int i = 0; i < 6; i++) chk($sformatf("on_s%0d", i), on_cnt[i], exp_s[i]);
		chk("period_single", win, 16'h0028);
		wait_rise();
		n = 0;
		while (sync === 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk("sync_width", 16'(n), 16'h0004);
		repeat (6) @(negedge clk);
		chk("half_first", {15'h0000, status[3]}, 16'h0000);
		repeat (15) @(negedge clk);
		chk("half_second", {15'h0000, status[3]}, 16'h0001);
		$display("test single done");
		// The mode bit is read live; min pulse zero lets the clamp alone decide phase C.
		@(posedge clk);
		mode <= 16'h0040;
		wr(2, 16'h0000);
		wr(6, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			wait_rise();
			st = status[3];
			@(posedge clk);
			@(negedge clk);
			if (i >= 4) chk("half_window", win, 16'h0014);
			if (i >= 4 && st === 1'b0) begin
				for (int j = 0; j < 6; j++) begin
					chk($sformatf("on_d%0d", j), on_cnt[j] + prv[j], exp_d[j]);
				end
			end
			prv = on_cnt;
			wr(4, st ? 16'h000C : 16'h000D);
		end
		chk("shoot_double", {15'h0000, shoot}, 16'h0000);
		$display("test double done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("gates_reset", {10'h000, gate}, 16'h0000);
		rst_n <= 1'b1;
		wr(0, 16'h0014);
		t0 = c0;
		wr(4, 16'h000C);
		wr(5, 16'h0008);
		wr(6, 16'h0003);
		wait_rise();
		chk("start_double", 16'(cyc - t0), 16'h0014);
		chk("shoot_through", {15'h0000, shoot}, 16'h0000);
		$display("test restart done");
		final_report();
	end
endmodule
